// >>> design/cdd_defs.vh
`ifndef CDD_DEFS_VH
`define CDD_DEFS_VH

// entry sizes in bytes per addressing mode
`define CDD_ENTRY_BYTES_32   16
`define CDD_ENTRY_BYTES_64   32
// 32-bit layout
`define CDD_L32_LEN_HI       63
`define CDD_L32_LEN_LO       40
`define CDD_L32_EP           38
`define CDD_L32_LAST         37
`define CDD_L32_IRQ          36
`define CDD_L32_OP_HI        35
`define CDD_L32_OP_LO        32
`define CDD_L32_PTR_HI       31
// 64-bit layout
`define CDD_L64_EP           102
`define CDD_L64_LAST         101
`define CDD_L64_IRQ          100
`define CDD_L64_OP_HI        99
`define CDD_L64_OP_LO        96
`define CDD_L64_LEN_HI       95
`define CDD_L64_LEN_LO       64
`define CDD_L64_PTR_HI       63
// cipher setup entry fields (low 64 bits, same in both modes)
`define CDD_CS_SIZE_HI       55
`define CDD_CS_SIZE_LO       40
`define CDD_CS_TWO_KEY       31
`define CDD_CS_KEY_HI        23
`define CDD_CS_KEY_MAX       24'h0000ff
`define CDD_XTS_WRAP_MAX     16'h0080
`define CDD_XTS_WRAP_ADD     17'h10000
// operation codes
`define CDD_OP_COMP          4'h0
`define CDD_OP_DECOMP        4'h1
`define CDD_OP_PASS          4'h2
`define CDD_OP_WRKEY         4'h3
`define CDD_OP_COMP_ENC      4'h4
`define CDD_OP_DEC_DECR      4'h5
`define CDD_OP_DECR          4'h7
`define CDD_OP_COMP_HASH     4'h8
`define CDD_OP_HASH          4'ha
`define CDD_OP_COMP_ENC_HASH 4'hc
`define CDD_OP_ENC_HASH      4'he

`endif

// >>> design/cdd_opcode_check.v
`timescale 1ns/1ps
`default_nettype none
`include "cdd_defs.vh"

// classifies an operation code; purely combinational
module cdd_opcode_check (
  input  wire [3:0] op,          // operation code
  output reg        valid,       // code is defined
  output reg        is_cipher,   // code needs a cipher setup entry
  output reg        is_hash      // first destination is the hash buffer
);
  // decode table of the defined codes
  always @* begin
    valid     = 1'b1;
    is_cipher = 1'b0;
    is_hash   = 1'b0;
    case (op)
      `CDD_OP_COMP, `CDD_OP_DECOMP, `CDD_OP_PASS, `CDD_OP_WRKEY: valid = 1'b1;
      `CDD_OP_COMP_ENC, `CDD_OP_DEC_DECR, `CDD_OP_DECR: is_cipher = 1'b1;
      `CDD_OP_COMP_HASH, `CDD_OP_HASH: is_hash = 1'b1;
      `CDD_OP_COMP_ENC_HASH, `CDD_OP_ENC_HASH: begin
        is_cipher = 1'b1;
        is_hash   = 1'b1;
      end
      default: valid = 1'b0;
    endcase
  end
endmodule // cdd_opcode_check

`default_nettype wire

// >>> design/cdd_decoder.v
`timescale 1ns/1ps
`default_nettype none
`include "cdd_defs.vh"

// Functional notes
// - user-data entry is never written back
// - destinations are filled strictly in order
// - hash commands: first destination is hash buffer
// - entries fetched as 16 or 32 bytes
// - 32-bit entry field positions decoded
// - 64-bit entry field positions decoded
// - last flag ends the command
// - opcode, irq, endian only from first entries
// - irq bit requests completion interrupt
// - operation code table decoded
// - xts sector sizes up to 0x80 wrap
// - gcm size field is aad length
// - cipher opcode limited to five values
// - bit 31 selects two-key fetch
// - key index above 255 reserved
// - completion clears the done flag
// - any decode error, or engine error while running, sets the error flag
module cdd_decoder #(
  parameter ENTRY_W = 256                  // widest entry in bits
) (
  input  wire               REF_CLK,       // 125 MHz clock
  input  wire               RESET_N,       // synchronous reset, active low
  input  wire               ADDR_MODE_64,  // static: 1 selects 64-bit entries
  input  wire               ENTRY_VALID,   // entry word offered
  output wire               ENTRY_READY,   // entry word taken
  input  wire               ENTRY_IS_SRC,  // 1 source entry, 0 destination entry
  input  wire [ENTRY_W-1:0] ENTRY_DATA,    // fetched entry bytes
  output wire [5:0]         FETCH_BYTES,   // bytes to fetch per entry
  output reg                SRC_BUF_VALID, // source buffer pulse
  output reg                DST_BUF_VALID, // destination buffer pulse
  output reg  [63:0]        BUF_POINTER,   // buffer address
  output reg  [31:0]        BUF_LENGTH,    // buffer length in bytes
  output reg  [15:0]        DST_INDEX,     // order of destination buffer
  output reg                HASH_BUF,      // this destination is the hash buffer
  output reg  [3:0]         OP_CODE,       // command operation
  output reg                ENDIAN_SEL,    // endian_selector_bit of the command
  output reg                IRQ_WANTED,    // completion interrupt requested
  output reg  [3:0]         CIPHER_OP,     // cipher_operation_code
  output reg                TWO_KEY_FETCH, // key manager fetches two keys
  output reg  [7:0]         KEY_SLOT,      // key store index
  output reg  [16:0]        SECTOR_BYTES,  // xts sector size in bytes
  output reg  [15:0]        AAD_BYTES,     // gcm aad length
  output reg                ENGINE_START,  // command start pulse
  input  wire               ENGINE_DONE,   // engine finished the command
  input  wire               ENGINE_ERROR,  // engine saw an error
  output reg                RESULT_WRITE,  // write result entry pulse
  output reg                RESULT_DONE,   // done flag value to write
  output reg                RESULT_ERR,    // error flag value to write
  output reg                CMD_IRQ,       // completion interrupt pulse
  output wire               BUSY           // command in progress
);

  localparam ST_FIRST = 4'b0001;  // awaiting first source/destination entries
  localparam ST_BUFS  = 4'b0010;  // passing buffer entries
  localparam ST_RUN   = 4'b0100;  // engine running
  localparam ST_DONE  = 4'b1000;  // write result

  // the cipher setup entry admits only the five cipher commands
  function cipher_op_ok;
    input [3:0] code;
    begin
      case (code)
        `CDD_OP_COMP_ENC,
        `CDD_OP_DEC_DECR,
        `CDD_OP_DECR,
        `CDD_OP_COMP_ENC_HASH,
        `CDD_OP_ENC_HASH: cipher_op_ok = 1'b1;
        default:          cipher_op_ok = 1'b0;
      endcase
    end
  endfunction

  reg  [3:0]  state;
  reg  [3:0]  next_state;
  reg         src_first_seen;
  reg         dst_first_seen;
  reg         src_ended;
  reg         dst_ended;
  reg         src_setup_next;
  reg         op_bad;
  reg         started;
  reg         err_acc;

  // field extraction per addressing mode
  reg  [63:0] f_ptr;
  reg  [31:0] f_len;
  reg  [3:0]  f_op;
  reg         f_last;
  reg         f_irq;
  reg         f_ep;

  always @* begin
    if (ADDR_MODE_64) begin
      f_ptr  = ENTRY_DATA[`CDD_L64_PTR_HI:0];
      f_len  = ENTRY_DATA[`CDD_L64_LEN_HI:`CDD_L64_LEN_LO];
      f_op   = ENTRY_DATA[`CDD_L64_OP_HI:`CDD_L64_OP_LO];
      f_last = ENTRY_DATA[`CDD_L64_LAST];
      f_irq  = ENTRY_DATA[`CDD_L64_IRQ];
      f_ep   = ENTRY_DATA[`CDD_L64_EP];
    end else begin
      f_ptr  = {32'h00000000, ENTRY_DATA[`CDD_L32_PTR_HI:0]};
      f_len  = {8'h00, ENTRY_DATA[`CDD_L32_LEN_HI:`CDD_L32_LEN_LO]};
      f_op   = ENTRY_DATA[`CDD_L32_OP_HI:`CDD_L32_OP_LO];
      f_last = ENTRY_DATA[`CDD_L32_LAST];
      f_irq  = ENTRY_DATA[`CDD_L32_IRQ];
      f_ep   = ENTRY_DATA[`CDD_L32_EP];
    end
  end

  // fetch size follows the static mode
  assign FETCH_BYTES = ADDR_MODE_64 ? 6'd`CDD_ENTRY_BYTES_64 : 6'd`CDD_ENTRY_BYTES_32;

  wire op_valid;
  wire op_cipher;
  wire op_hash;
  cdd_opcode_check u_opcheck (
    .op        (f_op),
    .valid     (op_valid),
    .is_cipher (op_cipher),
    .is_hash   (op_hash)
  );

  // cipher setup entry sits at the same positions in both modes
  wire [15:0] cs_size  = ENTRY_DATA[`CDD_CS_SIZE_HI:`CDD_CS_SIZE_LO];
  wire [23:0] cs_key   = ENTRY_DATA[`CDD_CS_KEY_HI:0];
  wire [3:0]  cs_op    = ENTRY_DATA[`CDD_L32_OP_HI:`CDD_L32_OP_LO];
  wire        key_bad  = (cs_key > `CDD_CS_KEY_MAX);
  // in 64-bit mode the setup command bits can disagree with bits 99:96,
  // so they are screened on their own rather than trusting the entry opcode
  wire        cs_op_bad = !cipher_op_ok(cs_op);

  // entries after the last flag on a side are refused by not being accepted
  wire side_open = ENTRY_IS_SRC ? !src_ended : !dst_ended;
  assign ENTRY_READY = (state == ST_FIRST || state == ST_BUFS) && side_open;
  wire take = ENTRY_VALID && ENTRY_READY;
  wire first_entry = ENTRY_IS_SRC ? !src_first_seen : !dst_first_seen;
  wire both_ended = (src_ended || (take && ENTRY_IS_SRC && f_last))
                  && (dst_ended || (take && !ENTRY_IS_SRC && f_last));

  // busy also covers a half-fetched command, so a host never sees a false idle
  // between the first source and the first destination entry
  assign BUSY = (state != ST_FIRST) || src_first_seen || dst_first_seen;

  // state transitions
  always @* begin
    next_state = state;
    case (state)
      ST_FIRST: begin
        // both first entries seen: the next take moves on to plain buffers
        if (take && src_first_seen && dst_first_seen)
          next_state = ST_BUFS;
        else if (both_ended)
          next_state = op_bad ? ST_DONE : ST_RUN;
      end
      ST_BUFS: begin
        // a rejected command skips the engine and goes straight to the result
        if (both_ended)
          next_state = (op_bad || err_acc) ? ST_DONE : ST_RUN;
      end
      ST_RUN: begin
        // engine errors are only collected while it runs
        if (ENGINE_DONE)
          next_state = ST_DONE;
      end
      ST_DONE: begin
        // one cycle to launch the result write, then idle again
        next_state = ST_FIRST;
      end
      default:  next_state = ST_FIRST;
    endcase
  end

  // main sequential decode
  always @(posedge REF_CLK) begin
    if (!RESET_N) begin
      state          <= ST_FIRST;
      src_first_seen <= 1'b0;
      dst_first_seen <= 1'b0;
      src_ended      <= 1'b0;
      dst_ended      <= 1'b0;
      src_setup_next <= 1'b0;
      op_bad         <= 1'b0;
      started        <= 1'b0;
      err_acc        <= 1'b0;
      SRC_BUF_VALID  <= 1'b0;
      DST_BUF_VALID  <= 1'b0;
      BUF_POINTER    <= 64'h0;
      BUF_LENGTH     <= 32'h0;
      DST_INDEX      <= 16'h0;
      HASH_BUF       <= 1'b0;
      OP_CODE        <= 4'h0;
      ENDIAN_SEL     <= 1'b0;
      IRQ_WANTED     <= 1'b0;
      CIPHER_OP      <= 4'h0;
      TWO_KEY_FETCH  <= 1'b0;
      KEY_SLOT       <= 8'h00;
      SECTOR_BYTES   <= 17'h0;
      AAD_BYTES      <= 16'h0;
      ENGINE_START   <= 1'b0;
      RESULT_WRITE   <= 1'b0;
      RESULT_DONE    <= 1'b0;
      RESULT_ERR     <= 1'b0;
      CMD_IRQ        <= 1'b0;
    end else begin
      state         <= next_state;
      SRC_BUF_VALID <= 1'b0;
      DST_BUF_VALID <= 1'b0;
      ENGINE_START  <= 1'b0;
      RESULT_WRITE  <= 1'b0;
      CMD_IRQ       <= 1'b0;
      if (ENGINE_ERROR && state == ST_RUN) err_acc <= 1'b1;
      if (take) begin
        if (f_last) begin
          if (ENTRY_IS_SRC) src_ended <= 1'b1;
          else dst_ended <= 1'b1;
        end
        if (first_entry) begin
          // command-wide bits come only from the first entries
          if (ENTRY_IS_SRC) src_first_seen <= 1'b1;
          else dst_first_seen <= 1'b1;
          OP_CODE    <= f_op;
          ENDIAN_SEL <= f_ep;
          IRQ_WANTED <= f_irq;
          if (!op_valid) op_bad <= 1'b1;
          if (ENTRY_IS_SRC && op_cipher) begin
            // first source is the setup entry, not a buffer
            CIPHER_OP     <= cs_op;
            TWO_KEY_FETCH <= ENTRY_DATA[`CDD_CS_TWO_KEY];
            KEY_SLOT      <= cs_key[7:0];
            AAD_BYTES     <= cs_size;
            if (cs_size <= `CDD_XTS_WRAP_MAX)
              SECTOR_BYTES <= `CDD_XTS_WRAP_ADD + {1'b0, cs_size};
            else
              SECTOR_BYTES <= {1'b0, cs_size};
            if (key_bad) op_bad <= 1'b1;
            // a setup entry with a non-cipher command is rejected as well
            if (cs_op_bad) op_bad <= 1'b1;
          end else if (ENTRY_IS_SRC) begin
            SRC_BUF_VALID <= 1'b1;
            BUF_POINTER   <= f_ptr;
            BUF_LENGTH    <= f_len;
          end else begin
            // hash commands reserve destination 0 for the digest
            DST_BUF_VALID <= 1'b1;
            HASH_BUF      <= op_hash;
            DST_INDEX     <= 16'h0;
            BUF_POINTER   <= f_ptr;
            BUF_LENGTH    <= f_len;
          end
        end else begin
          // later entries: their op, irq and endian bits are ignored
          BUF_POINTER <= f_ptr;
          BUF_LENGTH  <= f_len;
          if (ENTRY_IS_SRC) begin
            SRC_BUF_VALID <= 1'b1;
          end else begin
            DST_BUF_VALID <= 1'b1;
            HASH_BUF      <= 1'b0;
            DST_INDEX     <= DST_INDEX + 16'h1;
          end
        end
      end
      // engine never starts on a command rejected before the entry that ends it is taken
      if ((state == ST_FIRST || state == ST_BUFS) && next_state == ST_RUN)
        ENGINE_START <= 1'b1;
      if (state == ST_DONE) begin
        // only the result entry is written; user data is untouched
        RESULT_WRITE   <= 1'b1;
        RESULT_DONE    <= 1'b0;
        RESULT_ERR     <= op_bad || err_acc;
        CMD_IRQ        <= IRQ_WANTED;
        src_first_seen <= 1'b0;
        dst_first_seen <= 1'b0;
        src_ended      <= 1'b0;
        dst_ended      <= 1'b0;
        op_bad         <= 1'b0;
        err_acc        <= 1'b0;
      end
    end
  end
endmodule // cdd_decoder

`default_nettype wire

// >>> test/cdd_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cdd_chk #(parameter ENTRY_W = 256) (
  input wire logic               REF_CLK,      // clock
  input wire logic               RESET_N,      // sync reset
  input wire logic               ADDR_MODE_64, // mode
  input wire logic               ENTRY_VALID,  // offer
  input wire logic               ENTRY_READY,  // take
  input wire logic               ENTRY_IS_SRC, // side
  input wire logic [ENTRY_W-1:0] ENTRY_DATA,   // entry
  input wire logic [5:0]         FETCH_BYTES,  // fetch size
  input wire logic               DST_BUF_VALID,// dst pulse
  input wire logic [63:0]        BUF_POINTER,  // address
  input wire logic [31:0]        BUF_LENGTH,   // length
  input wire logic [15:0]        DST_INDEX,    // dst order
  input wire logic               IRQ_WANTED,   // irq level
  input wire logic [16:0]        SECTOR_BYTES, // sector
  input wire logic [15:0]        AAD_BYTES,    // aad
  input wire logic               ENGINE_START, // start
  input wire logic               ENGINE_DONE,  // done in
  input wire logic               ENGINE_ERROR, // error in
  input wire logic               RESULT_WRITE, // result pulse
  input wire logic               RESULT_DONE,  // done flag
  input wire logic               RESULT_ERR,   // error flag
  input wire logic               CMD_IRQ       // irq pulse
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  wire       tk = ENTRY_VALID && ENTRY_READY && !ENTRY_IS_SRC;
  logic [15:0] dcnt;
  // destination count per command, cleared once the result is out
  always @(posedge REF_CLK)
    if (!RESET_N || RESULT_WRITE) dcnt <= 16'h0;
    else if (DST_BUF_VALID) dcnt <= dcnt + 16'h1;
  property p_fetch; FETCH_BYTES == (ADDR_MODE_64 ? 6'h20 : 6'h10); endproperty
  a_fetch: assert property (p_fetch) else $error("fetch size wrong");
  property p_l32; tk && !ADDR_MODE_64 |=> DST_BUF_VALID && BUF_POINTER == {32'h0,
    $past(ENTRY_DATA[31:0])} && BUF_LENGTH == {8'h0, $past(ENTRY_DATA[63:40])}; endproperty
  a_l32: assert property (p_l32) else $error("32-bit fields wrong");
  property p_l64; tk && ADDR_MODE_64 |=> DST_BUF_VALID &&
    BUF_POINTER == $past(ENTRY_DATA[63:0]) && BUF_LENGTH == $past(ENTRY_DATA[95:64]); endproperty
  a_l64: assert property (p_l64) else $error("64-bit fields wrong");
  property p_order; DST_BUF_VALID |-> DST_INDEX == dcnt; endproperty
  a_order: assert property (p_order) else $error("dst order wrong");
  property p_last; ENGINE_START |-> !ENTRY_READY ##1 !ENTRY_READY; endproperty
  a_last: assert property (p_last) else $error("entry taken after last");
  property p_irq; RESULT_WRITE |-> CMD_IRQ == IRQ_WANTED; endproperty
  a_irq: assert property (p_irq) else $error("irq pulse wrong");
  property p_done; RESULT_WRITE |-> !RESULT_DONE; endproperty
  a_done: assert property (p_done) else $error("done flag not cleared");
  property p_err; $past(ENGINE_START) && ENGINE_DONE && ENGINE_ERROR |->
    ##2 RESULT_WRITE && RESULT_ERR; endproperty
  a_err: assert property (p_err) else $error("error flag missing");
  property p_sec; AAD_BYTES != 16'h0 || SECTOR_BYTES != 17'h0 |-> SECTOR_BYTES ==
    (AAD_BYTES <= 16'h0080 ? {1'b0, AAD_BYTES} + 17'h10000 : {1'b0, AAD_BYTES}); endproperty
  a_sec: assert property (p_sec) else $error("sector size wrong");
  c_start: cover property (ENGINE_START);
  c_err:   cover property (RESULT_WRITE && RESULT_ERR);
  c_irq:   cover property (CMD_IRQ);
endmodule // cdd_chk
bind cdd_decoder cdd_chk #(.ENTRY_W(ENTRY_W)) cdd_chk_inst (.*);
`default_nettype wire

// >>> test/cdd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdd_host_model (
  input  wire logic         REF_CLK,      // clock
  input  wire logic         ENTRY_READY,  // device takes entry
  input  wire logic         SLOW,         // gap between entries
  output var  logic         ENTRY_VALID,  // entry offered
  output var  logic         ENTRY_IS_SRC, // side of entry
  output var  logic [255:0] ENTRY_DATA    // entry bits
);
  logic [256:0] q[$];
  logic         taken;
  logic         gap;
  initial {ENTRY_VALID, ENTRY_IS_SRC, ENTRY_DATA, taken, gap} = '0;
  // the bench queues entries as given, including reserved codes and an out-of-range key
  task push(input logic [256:0] x);
    q.push_back(x);
  endtask
  always @(posedge REF_CLK) taken <= ENTRY_VALID && ENTRY_READY;
  // held until taken; released lines toggle so a stale value never looks valid
  always @(negedge REF_CLK) begin
    gap = SLOW & ~gap;
    if (taken || !ENTRY_VALID) begin
      if (q.size() > 0 && !gap) begin
        {ENTRY_IS_SRC, ENTRY_DATA} = q.pop_front();
        ENTRY_VALID = 1'b1;
      end else begin
        ENTRY_VALID = 1'b0;
        {ENTRY_IS_SRC, ENTRY_DATA} = ~{ENTRY_IS_SRC, ENTRY_DATA};
      end
    end
  end
endmodule // cdd_host_model
`default_nettype wire

// >>> test/cdd_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
module cdd_decoder_test;
  logic         REF_CLK, RESET_N, ADDR_MODE_64, ENGINE_DONE, ENGINE_ERROR, SLOW;
  wire          ENTRY_VALID, ENTRY_READY, ENTRY_IS_SRC, SRC_BUF_VALID, DST_BUF_VALID;
  wire  [255:0] ENTRY_DATA;
  wire  [5:0]   FETCH_BYTES;
  wire  [63:0]  BUF_POINTER;
  wire  [31:0]  BUF_LENGTH;
  wire  [15:0]  DST_INDEX, AAD_BYTES;
  wire  [3:0]   OP_CODE, CIPHER_OP;
  wire  [7:0]   KEY_SLOT;
  wire  [16:0]  SECTOR_BYTES;
  wire          HASH_BUF, ENDIAN_SEL, IRQ_WANTED, TWO_KEY_FETCH, ENGINE_START, BUSY;
  wire          RESULT_WRITE, RESULT_DONE, RESULT_ERR, CMD_IRQ;
  integer       seed, bad_count, checks, o;
  logic [97:0]  exq[$];
  logic [97:0]  e;
  logic [2:0]   ex_res;
  logic [255:0] su;
  logic [1:0]   starts;
  logic [31:0]  rb;
  logic [23:0]  key;
  logic [15:0]  sz;
  logic         wrote, cip, rsv;
  cdd_decoder cdd_decoder_inst (.*);
  cdd_host_model cdd_host_model_inst (.*);
  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  task chk(input string nm, input logic [127:0] s, x);
    checks++;
    if (s !== x) begin
      $display("[ERR] %s exp %h seen %h", nm, x, s);
      bad_count++;
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic [255:0] mk(input m, input [3:0] op, input i, ep, l,
                                input [31:0] n, input [63:0] p);
    mk = m ? {153'h0, ep, l, i, op, n, p} : {192'h0, n[23:0], 1'b0, ep, l, i, op, p[31:0]};
  endfunction
  // engine answers half a cycle after start, in the start pulse's own cycle; the error level is set per command
  always @(negedge REF_CLK) ENGINE_DONE <= ENGINE_START;
  // every buffer pulse must match the next queued expectation, in order
  always @(posedge REF_CLK) if (RESET_N) begin
    if (SRC_BUF_VALID || DST_BUF_VALID) begin
      e = exq.size() > 0 ? exq.pop_front() : '1;
      chk("buf", {SRC_BUF_VALID, DST_BUF_VALID && HASH_BUF, BUF_POINTER, BUF_LENGTH}, e);
    end
    if (ENGINE_START) starts <= starts + 2'h1;
    if (RESULT_WRITE) begin
      chk("res", {RESULT_DONE, RESULT_ERR, CMD_IRQ}, ex_res);
      wrote <= 1'b1;
    end
  end
  // later entries carry inverted op, irq and endian bits, which must be ignored
  task automatic cmd(input [3:0] op, input irq, ep, ee, cp, bad);
    integer k;
    logic f;
    logic [63:0] p;
    logic [31:0] n;
    ENGINE_ERROR = ee;
    wrote = 1'b0;
    starts = 2'h0;
    ex_res = {1'b0, bad | ee, irq};
    if (cp) cdd_decoder_test.cdd_host_model_inst.push({1'b1, su});
    for (k = 0; k < 4; k++) begin
      f = (k == 1) || (k == 0 && !cp);
      p = {$random(seed), $random(seed)};
      n = $random(seed);
      if (!ADDR_MODE_64) {p[63:32], n[31:24]} = 40'h0;
      if (k[0]) n[2:0] = 3'h0;
      cdd_decoder_test.cdd_host_model_inst.push({!k[0], mk(ADDR_MODE_64, f ? op : ~op,
        f ? irq : ~irq, f ? ep : ~ep, k > 1, n, p)});
      exq.push_back({!k[0], k == 1 && op[3] && !op[0], p, n});
    end
    for (k = 0; k < 200 && !wrote; k++) @(negedge REF_CLK);
    chk("wait", {wrote, exq.size() == 0, BUSY}, 3'h6);
    chk("cmd", {OP_CODE, IRQ_WANTED, ENDIAN_SEL, starts}, {op, irq, ep, 1'b0, !bad});
  endtask
  initial begin
    {RESET_N, ADDR_MODE_64, ENGINE_ERROR, SLOW} = 4'h0;
    {seed, bad_count, checks} = {32'h0e86, 64'h0};
    for (int mi = 0; mi < 2; mi++) begin
      @(negedge REF_CLK);
      {RESET_N, ADDR_MODE_64, SLOW} = {1'b0, mi[0], mi[0]};
      repeat (8) @(negedge REF_CLK);
      RESET_N = 1'b1;
      chk("fetch", FETCH_BYTES, ADDR_MODE_64 ? 6'h20 : 6'h10);
      for (o = 0; o < 16; o++) if (o != 3) begin
        cip = o == 4 || o == 5 || o == 7 || o == 12 || o == 14;
        rsv = o == 6 || o == 9 || o == 11 || o == 13 || o == 15;
        rb = $random(seed);
        key = o == 5 ? 24'h000100 : o == 7 ? 24'h0000ff : {16'h0, rb[7:0]};
        sz = o[1:0] == 0 ? 16'h0000 : o[1:0] == 1 ? 16'h0080 : o[1:0] == 2 ? 16'h0081 : 16'hffff;
        su = mk(ADDR_MODE_64, o[3:0], o[0], o[1], 1'b0, 32'h0, 64'h0);
        {su[55:40], su[35:31], su[23:0]} = {sz, o[3:0], o[1], key};
        cmd(o[3:0], o[0], o[1], o[2] && !rsv && o != 5, cip, rsv || o == 5);
        if (cip) chk("cip", {CIPHER_OP, TWO_KEY_FETCH, o == 5 ? 8'h0 : KEY_SLOT, SECTOR_BYTES,
          AAD_BYTES}, {o[3:0], o[1], key[7:0], sz <= 16'h0080 ? {1'b0, sz} + 17'h10000 :
          {1'b0, sz}, sz});
      end
    end
    end_sim;
  end
  // hang guard, well beyond the expected run
  initial begin
    #200000;
    bad_count++;
    end_sim;
  end
endmodule // cdd_decoder_test
`default_nettype wire
